// ==== bench/codec_clock_page_control_sva.sv ====
`timescale 1ns/1ps
module codec_clock_page_control_sva
   import codec_clk_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       ce_in,
   input wire logic       bvalid_out,
   input wire logic       mclk_pin_in,
   input wire logic       bclk_pin_in,
   input wire logic       gpio_pin_in,
   input wire logic       din_pin_in,
   input wire logic       pll_clk_in,
   input wire logic [7:0] page_out,
   input wire logic       pll_range_out,
   input wire logic [1:0] pll_ref_sel_out,
   input wire logic [1:0] core_clock_source_out,
   input wire logic       pll_power_out,
   input wire logic [3:0] pll_p_div_out,
   input wire logic [2:0] pll_r_mult_out,
   input wire logic       pll_ref_level_out,
   input wire logic       core_clock_level_out,
   input wire logic       soft_reset_out
);
   logic [3:0] ref_v;
   logic [3:0] core_v;
   logic       ref_pin;
   logic       core_pin;
   assign ref_v    = {din_pin_in, gpio_pin_in, bclk_pin_in, mclk_pin_in};
   assign core_v   = {pll_clk_in, gpio_pin_in, bclk_pin_in, mclk_pin_in};
   assign ref_pin  = ref_v[pll_ref_sel_out];
   assign core_pin = core_v[core_clock_source_out];

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // Only a committed write or the soft reset may move the page
   property p_page_by_write;
      $changed(page_out) |-> $rose(bvalid_out) || $past(soft_reset_out);
   endproperty
   a_page_by_write: assert property (p_page_by_write)
      else $error("page moved without a write");

   property p_mux_by_write;
      $changed({pll_range_out, pll_ref_sel_out, core_clock_source_out})
         |-> $rose(bvalid_out) || $past(soft_reset_out);
   endproperty
   a_mux_by_write: assert property (p_mux_by_write)
      else $error("clock selection moved without a write");

   property p_pll_by_write;
      $changed({pll_power_out, pll_p_div_out, pll_r_mult_out})
         |-> $rose(bvalid_out) || $past(soft_reset_out);
   endproperty
   a_pll_by_write: assert property (p_pll_by_write)
      else $error("pll setting moved without a write");

   property p_p_legal;
      pll_p_div_out inside {[4'h1:4'h8]};
   endproperty
   a_p_legal: assert property (p_p_legal)
      else $error("predivider outside one to eight");

   // Illegal codes are dropped, so R never leaves one to four
   property p_r_legal;
      pll_r_mult_out inside {[3'h1:3'h4]};
   endproperty
   a_r_legal: assert property (p_r_legal)
      else $error("multiplier outside one to four");

   property p_srst_pulse;
      soft_reset_out |-> $rose(bvalid_out) ##1 !soft_reset_out;
   endproperty
   a_srst_pulse: assert property (p_srst_pulse)
      else $error("soft reset pulse not a single write cycle");

   property p_srst_clears;
      soft_reset_out && ce_in |=> page_out == 8'h00 && !pll_range_out && !pll_power_out
         && pll_ref_sel_out == 2'h0 && core_clock_source_out == 2'h0
         && pll_p_div_out == 4'h1 && pll_r_mult_out == 3'h1;
   endproperty
   a_srst_clears: assert property (p_srst_clears)
      else $error("soft reset left a field set");

   property p_ref_level;
      ce_in |=> pll_ref_level_out == $past(ref_pin);
   endproperty
   a_ref_level: assert property (p_ref_level)
      else $error("pll reference level not the chosen pin");

   property p_core_level;
      ce_in |=> core_clock_level_out == $past(core_pin);
   endproperty
   a_core_level: assert property (p_core_level)
      else $error("core clock level not the chosen pin");
endmodule : codec_clock_page_control_sva

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench
   import codec_clk_pkg::*;
;
   logic        clk_in      = 1'b0;
   logic        rst_in      = 1'b1;
   logic        ce_in       = 1'b1;
   logic [11:0] awaddr_in   = 12'h000;
   logic        awvalid_in  = 1'b0;
   logic [31:0] wdata_in    = 32'h00000000;
   logic [3:0]  wstrb_in    = 4'hF;
   logic        wvalid_in   = 1'b0;
   logic        bready_in   = 1'b0;
   logic [11:0] araddr_in   = 12'h000;
   logic        arvalid_in  = 1'b0;
   logic        rready_in   = 1'b0;
   logic [4:0]  pins        = 5'h00;
   logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
   logic [1:0]  bresp_out, rresp_out, pll_ref_sel_out, core_clock_source_out, resp;
   logic [31:0] rdata_out;
   logic [7:0]  page_out, adc_filt_cfg_out, dac_filt_cfg_out;
   logic        pll_range_out, pll_power_out, pll_ref_level_out, core_clock_level_out;
   logic        soft_reset_out;
   logic [3:0]  pll_p_div_out;
   logic [2:0]  pll_r_mult_out;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          srst_cnt    = 0;
   int          i;
   logic [7:0]  d5 [4]      = '{8'hF4, 8'h83, 8'h82, 8'h91};
   logic [7:0]  o5 [4]      = '{8'hBC, 8'hC3, 8'hC2, 8'h89};
   logic [7:0]  e5 [4]      = '{8'hF4, 8'h83, 8'h82, 8'h91};
   logic [7:0]  pg [8]      = '{8'h08, 8'h10, 8'h1A, 8'h22, 8'h2C, 8'h34, 8'h3E, 8'h46};

   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) if (soft_reset_out) srst_cnt++;

   codec_clock_page_control u_codec_clock_page_control (
      .clk_in, .rst_in, .ce_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in,
      .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
      .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out,
      .rready_in, .mclk_pin_in(pins[0]), .bclk_pin_in(pins[1]), .gpio_pin_in(pins[2]),
      .din_pin_in(pins[3]), .pll_clk_in(pins[4]), .page_out, .pll_range_out,
      .pll_ref_sel_out, .core_clock_source_out, .pll_power_out, .pll_p_div_out,
      .pll_r_mult_out, .pll_ref_level_out, .core_clock_level_out, .soft_reset_out,
      .adc_filt_cfg_out, .dac_filt_cfg_out
   );

   function automatic logic [11:0] ra(input int idx);
      return 12'(idx * 4);
   endfunction : ra

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   // A hung handshake ends the run rather than stalling it
   task automatic bail(input logic done);
      if (!done) begin
         miscompares++;
         give_verdict();
      end
   endtask : bail

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      logic b;
      int   n;
      awaddr_in  <= a;
      awvalid_in <= 1'b1;
      wdata_in   <= {24'h000000, d};
      wvalid_in  <= 1'b1;
      bready_in  <= 1'b1;
      b = 1'b0;
      for (n = 0; n < 40 && !b; n++) begin
         @(negedge clk_in);
         aw = awvalid_in & awready_out;
         w = wvalid_in & wready_out;
         b = bvalid_out;
         resp = bresp_out;
         @(posedge clk_in);
         if (aw) awvalid_in <= 1'b0;
         if (w) wvalid_in <= 1'b0;
      end
      bail(b);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic g;
      logic r;
      int   n;
      araddr_in  <= a;
      arvalid_in <= 1'b1;
      rready_in  <= 1'b1;
      r = 1'b0;
      for (n = 0; n < 40 && !r; n++) begin
         @(negedge clk_in);
         g = arvalid_in & arready_out;
         r = rvalid_out;
         resp = rresp_out;
         if (r) chk(rdata_out, {24'h000000, e});
         @(posedge clk_in);
         if (g) arvalid_in <= 1'b0;
      end
      bail(r);
   endtask : rd

   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(ra(0), 8'h00);
      rd(ra(1), 8'h00);
      rd(ra(3), 8'h00);
      rd(ra(4), 8'h00);
      rd(ra(5), 8'h11);
      // Pins chosen so the selected reference and core pins always differ
      for (i = 0; i < 4; i++) begin
         pins <= (i == 1 || i == 2) ? 5'h04 : 5'h01;
         wr(ra(4), {1'b0, i[0], 2'b00, i[1:0], ~i[1:0]});
         rd(ra(4), {1'b0, i[0], 2'b00, i[1:0], ~i[1:0]});
         @(negedge clk_in);
         chk(32'(pll_range_out), 32'(i % 2));
         chk(32'(pll_ref_sel_out), 32'(i));
         chk(32'(core_clock_source_out), 32'(3 - i));
         chk(32'(pll_ref_level_out), 32'(!i[0]));
         chk(32'(core_clock_level_out), 32'(i[0]));
         @(posedge clk_in);
      end
      // Every legal R code once; the host never programs the forbidden ones
      for (i = 0; i < 4; i++) begin
         wr(ra(5), d5[i]);
         rd(ra(5), e5[i]);
         @(negedge clk_in);
         chk({pll_power_out, pll_p_div_out, pll_r_mult_out}, 32'(o5[i]));
         @(posedge clk_in);
      end
      wr(ra(1), 8'h00);
      rd(ra(5), 8'h91);
      wr(ra(1), 8'h01);
      rd(ra(1), 8'h00);
      chk(srst_cnt, 1);
      rd(ra(4), 8'h00);
      rd(ra(5), 8'h11);
      wr(ra(0), 8'h08);
      rd(ra(0), 8'h08);
      wr(ra(1), 8'h5A);
      rd(ra(1), 8'h5A);
      for (i = 0; i < 8; i++) begin
         wr(ra(0), pg[i]);
         wr(ra(i % 2 ? 127 : 8), 8'(i * 17 + 3));
      end
      for (i = 0; i < 8; i++) begin
         wr(ra(0), pg[i]);
         rd(ra(i % 2 ? 127 : 8), 8'(i * 17 + 3));
      end
      wr(ra(0), 8'h1A);
      rd(ra(2), 8'h00);
      wr(ra(0), 8'h11);
      wr(ra(8), 8'h77);
      rd(ra(8), 8'h00);
      wr(ra(0), 8'h2C);
      wr(ra(1), 8'hA5);
      @(negedge clk_in);
      chk({adc_filt_cfg_out, dac_filt_cfg_out}, 32'h00005AA5);
      @(posedge clk_in);
      wr(12'h204, 8'h01);
      chk(32'(resp), 32'h00000002);
      rd(12'h200, 8'h00);
      chk(32'(resp), 32'h00000002);
      wr(ra(0), 8'h00);
      @(negedge clk_in);
      chk(32'(page_out), 32'h00000000);
      give_verdict();
   end
endmodule : testbench

bind codec_clock_page_control codec_clock_page_control_sva u_sva (
   .clk_in, .rst_in, .ce_in, .bvalid_out, .mclk_pin_in, .bclk_pin_in, .gpio_pin_in,
   .din_pin_in, .pll_clk_in, .page_out, .pll_range_out, .pll_ref_sel_out,
   .core_clock_source_out, .pll_power_out, .pll_p_div_out, .pll_r_mult_out,
   .pll_ref_level_out, .core_clock_level_out, .soft_reset_out
);

// ==== design/codec_clock_page_control.sv ====
`timescale 1ns/1ps
`include "codec_clk_defines.svh"

module codec_clock_page_control
   import codec_clk_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int SLOTS  = 36
) (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              ce_in,
   input  wire logic [ADDR_W-1:0] awaddr_in,
   input  wire logic              awvalid_in,
   output logic                   awready_out,
   input  wire logic [31:0]       wdata_in,
   input  wire logic [3:0]        wstrb_in,
   input  wire logic              wvalid_in,
   output logic                   wready_out,
   output logic [1:0]             bresp_out,
   output logic                   bvalid_out,
   input  wire logic              bready_in,
   input  wire logic [ADDR_W-1:0] araddr_in,
   input  wire logic              arvalid_in,
   output logic                   arready_out,
   output logic [31:0]            rdata_out,
   output logic [1:0]             rresp_out,
   output logic                   rvalid_out,
   input  wire logic              rready_in,
   input  wire logic              mclk_pin_in,
   input  wire logic              bclk_pin_in,
   input  wire logic              gpio_pin_in,
   input  wire logic              din_pin_in,
   input  wire logic              pll_clk_in,
   output logic [7:0]             page_out,
   output logic                   pll_range_out,
   output logic [1:0]             pll_ref_sel_out,
   output logic [1:0]             core_clock_source_out,
   output logic                   pll_power_out,
   output logic [3:0]             pll_p_div_out,
   output logic [2:0]             pll_r_mult_out,
   output logic                   pll_ref_level_out,
   output logic                   core_clock_level_out,
   output logic                   soft_reset_out,
   output logic [7:0]             adc_filt_cfg_out,
   output logic [7:0]             dac_filt_cfg_out
);

   localparam int SLOT_W = $clog2(SLOTS);
   localparam int MEM_D  = SLOTS * `COEF_REGS_PER_PG;
   localparam int IDX_W  = $clog2(MEM_D);

   logic [7:0]        page_r;
   logic              pll_range_r;
   clk_src_t          pll_ref_r;
   clk_src_t          core_src_r;
   logic              pll_power_r;
   logic [3:0]        p_div_r;
   logic [2:0]        r_mult_r;
   logic              pll_ref_level_r;
   logic              core_level_r;
   logic              srst_r;
   logic [7:0]        adc_cfg_r;
   logic [7:0]        dac_cfg_r;
   logic [7:0]        coef_mem [0:MEM_D-1];

   logic              awready_r;
   logic              wready_r;
   logic              aw_held_r;
   logic              w_held_r;
   logic [ADDR_W-1:0] wr_addr_r;
   logic [7:0]        wr_data_r;
   logic              wr_lane_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              arready_r;
   logic              rd_pend_r;
   logic [ADDR_W-1:0] rd_addr_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;

   logic              do_write;
   logic              wr_bad;
   logic              rd_bad;
   logic              wr_hit;
   logic [6:0]        wr_reg;
   logic [6:0]        rd_reg;
   region_t           wr_region;
   region_t           rd_region;
   logic [SLOT_W-1:0] wr_slot;
   logic [SLOT_W-1:0] rd_slot;
   logic [IDX_W-1:0]  wr_idx;
   logic [IDX_W-1:0]  rd_idx;
   logic              srst_hit;
   logic [7:0]        rd_byte;

   // Address above the 128-register page window is refused with SLVERR
   assign wr_reg   = wr_addr_r[`IDX_MSB:`IDX_LSB];
   assign rd_reg   = rd_addr_r[`IDX_MSB:`IDX_LSB];
   assign wr_bad   = |wr_addr_r[ADDR_W-1:`IDX_MSB+1];
   assign rd_bad   = |rd_addr_r[ADDR_W-1:`IDX_MSB+1];
   assign do_write = aw_held_r && w_held_r && !bvalid_r;
   assign wr_hit   = do_write && !wr_bad && wr_lane_r;
   assign srst_hit = wr_hit && wr_region == REGION_PAGE0 && wr_reg == `REG_SOFT_RST
                     && wr_data_r[`SRST_BIT]; // R7

   page_map_decoder #(.SLOT_W(SLOT_W)) wr_dec (
      .page_in    (page_r),
      .reg_in     (wr_reg),
      .region_out (wr_region),
      .slot_out   (wr_slot)
   );

   page_map_decoder #(.SLOT_W(SLOT_W)) rd_dec (
      .page_in    (page_r),
      .reg_in     (rd_reg),
      .region_out (rd_region),
      .slot_out   (rd_slot)
   );

   // Coefficient storage packs 120 bytes per page, slot-major
   assign wr_idx = IDX_W'(IDX_W'(wr_slot) * IDX_W'(`COEF_REGS_PER_PG)
                   + IDX_W'(wr_reg) - IDX_W'(`REG_COEF_FIRST));
   assign rd_idx = IDX_W'(IDX_W'(rd_slot) * IDX_W'(`COEF_REGS_PER_PG)
                   + IDX_W'(rd_reg) - IDX_W'(`REG_COEF_FIRST));

   // Page select and page-0 clock fields
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         page_r      <= `PAGE_RST; // R1
         pll_range_r <= `PLL_RANGE_RST;
         pll_ref_r   <= SRC_MCLK;
         core_src_r  <= SRC_MCLK;
         pll_power_r <= `PLL_PWR_RST;
         p_div_r     <= `PLL_P_RST;
         r_mult_r    <= `PLL_R_RST;
      end else if (ce_in) begin
         if (srst_r) begin
            page_r      <= `PAGE_RST; // R16
            pll_range_r <= `PLL_RANGE_RST;
            pll_ref_r   <= SRC_MCLK;
            core_src_r  <= SRC_MCLK;
            pll_power_r <= `PLL_PWR_RST;
            p_div_r     <= `PLL_P_RST;
            r_mult_r    <= `PLL_R_RST;
         end else if (wr_hit && wr_region == REGION_SELECT) begin
            page_r <= wr_data_r; // R1 R15
         end else if (wr_hit && wr_region == REGION_PAGE0 && wr_reg == `REG_CLK_MUX) begin
            pll_range_r <= wr_data_r[`PLL_RANGE_BIT]; // R9
            pll_ref_r   <= clk_src_t'(wr_data_r[`PLL_REF_MSB:`PLL_REF_LSB]); // R10
            core_src_r  <= clk_src_t'(wr_data_r[`CORE_SRC_MSB:`CORE_SRC_LSB]); // R11
         end else if (wr_hit && wr_region == REGION_PAGE0 && wr_reg == `REG_PLL_PR) begin
            pll_power_r <= wr_data_r[`PLL_PWR_BIT]; // R12
            // Code 000 means divide by eight
            if (wr_data_r[`PLL_P_MSB:`PLL_P_LSB] == 3'h0) begin
               p_div_r <= `PLL_P_EIGHT; // R13
            end else begin
               p_div_r <= {1'b0, wr_data_r[`PLL_P_MSB:`PLL_P_LSB]}; // R13
            end
            // Illegal R codes are dropped so the PLL never sees a bad ratio
            if (wr_data_r[`PLL_R_MSB:`PLL_R_LSB] >= `PLL_R_MIN
                && wr_data_r[`PLL_R_MSB:`PLL_R_LSB] <= `PLL_R_MAX) begin
               r_mult_r <= wr_data_r[`PLL_R_LSB+2:`PLL_R_LSB]; // R14
            end
         end
      end
   end

   // Self-clearing reset strobe, one cycle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         srst_r <= 1'b0;
      end else if (ce_in) begin
         srst_r <= srst_hit; // R7
      end
   end

   // Adaptive filter configuration
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         adc_cfg_r <= `FILT_CFG_RST;
         dac_cfg_r <= `FILT_CFG_RST;
      end else if (ce_in && wr_hit) begin
         if (wr_region == REGION_ADCCFG) begin
            adc_cfg_r <= wr_data_r; // R6
         end
         if (wr_region == REGION_DACCFG) begin
            dac_cfg_r <= wr_data_r; // R6
         end
      end
   end

   // Coefficient memory is not reset: contents are undefined until loaded
   always_ff @(posedge clk_in) begin
      if (ce_in && wr_hit && wr_region == REGION_COEF) begin
         coef_mem[wr_idx] <= wr_data_r; // R2 R3 R4 R5
      end
   end

   // Sampled pin levels through the selected muxes
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pll_ref_level_r <= 1'b0;
         core_level_r    <= 1'b0;
      end else if (ce_in) begin
         unique case (pll_ref_r)
            SRC_MCLK: pll_ref_level_r <= mclk_pin_in; // R10
            SRC_BCLK: pll_ref_level_r <= bclk_pin_in;
            SRC_GPIO: pll_ref_level_r <= gpio_pin_in;
            SRC_ALT:  pll_ref_level_r <= din_pin_in;
         endcase
         unique case (core_src_r)
            SRC_MCLK: core_level_r <= mclk_pin_in; // R11
            SRC_BCLK: core_level_r <= bclk_pin_in;
            SRC_GPIO: core_level_r <= gpio_pin_in;
            SRC_ALT:  core_level_r <= pll_clk_in;
         endcase
      end
   end

   // AXI write: address and data taken in either order, one write at a time
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= 8'h00;
         wr_lane_r <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
      end else if (ce_in) begin
         if (awvalid_in && awready_r) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            wr_addr_r <= awaddr_in;
         end
         if (wvalid_in && wready_r) begin
            wready_r  <= 1'b0;
            w_held_r  <= 1'b1;
            wr_data_r <= wdata_in[7:0];
            wr_lane_r <= wstrb_in[0];
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (bvalid_r && bready_in) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Read mux; reserved and self-clearing bits read as zero (R8 keeps writes clean)
   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_region)
         REGION_SELECT: rd_byte = page_r; // R15
         REGION_PAGE0: begin
            if (rd_reg == `REG_CLK_MUX) begin
               rd_byte = {1'b0, pll_range_r, 2'b00, pll_ref_r, core_src_r};
            end else if (rd_reg == `REG_PLL_PR) begin
               rd_byte = {pll_power_r, p_div_r[2:0], 1'b0, r_mult_r};
            end
         end
         REGION_ADCCFG: rd_byte = adc_cfg_r;
         REGION_DACCFG: rd_byte = dac_cfg_r;
         REGION_COEF:   rd_byte = coef_mem[rd_idx];
         REGION_NONE:   rd_byte = 8'h00;
         default:       rd_byte = 8'h00;
      endcase
   end

   // AXI read: one cycle to fetch, answer held until rready
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         arready_r <= 1'b1;
         rd_pend_r <= 1'b0;
         rd_addr_r <= '0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `RESP_OKAY;
      end else if (ce_in) begin
         if (arvalid_in && arready_r) begin
            arready_r <= 1'b0;
            rd_pend_r <= 1'b1;
            rd_addr_r <= araddr_in;
         end
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_bad ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            rresp_r   <= rd_bad ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (rvalid_r && rready_in) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign awready_out           = awready_r;
   assign wready_out            = wready_r;
   assign bvalid_out            = bvalid_r;
   assign bresp_out             = bresp_r;
   assign arready_out           = arready_r;
   assign rvalid_out            = rvalid_r;
   assign rdata_out             = rdata_r;
   assign rresp_out             = rresp_r;
   assign page_out              = page_r;
   assign pll_range_out         = pll_range_r;
   assign pll_ref_sel_out       = pll_ref_r;
   assign core_clock_source_out = core_src_r;
   assign pll_power_out         = pll_power_r;
   assign pll_p_div_out         = p_div_r;
   assign pll_r_mult_out        = r_mult_r;
   assign pll_ref_level_out     = pll_ref_level_r;
   assign core_clock_level_out  = core_level_r;
   assign soft_reset_out        = srst_r;
   assign adc_filt_cfg_out      = adc_cfg_r;
   assign dac_filt_cfg_out      = dac_cfg_r;

endmodule : codec_clock_page_control

// ==== design/page_map_decoder.sv ====
`timescale 1ns/1ps
`include "codec_clk_defines.svh"

module page_map_decoder
   import codec_clk_pkg::*;
#(
   parameter int SLOT_W = 6
) (
   input  wire logic [7:0]        page_in,
   input  wire logic [6:0]        reg_in,
   output region_t                region_out,
   output logic [SLOT_W-1:0]      slot_out
);

   logic       coef_reg;
   logic [7:0] offs;

   assign coef_reg = (reg_in >= `REG_COEF_FIRST);

   always_comb begin
      region_out = REGION_NONE;
      slot_out   = '0;
      offs       = 8'h00;
      if (reg_in == `REG_PAGE_SEL) begin
         region_out = REGION_SELECT; // R15
      end else if (page_in == `PAGE_ZERO) begin
         region_out = REGION_PAGE0;
      end else if (page_in >= `PAGE_ADC_A_FIRST && page_in <= `PAGE_ADC_A_LAST) begin
         offs = page_in - `PAGE_ADC_A_FIRST;
         if (coef_reg) begin
            region_out = REGION_COEF; // R2
            slot_out   = SLOT_W'(offs) + SLOT_W'(`SLOT_ADC_A);
         end else if (page_in == `PAGE_ADC_A_FIRST && reg_in == `REG_FILT_CFG) begin
            region_out = REGION_ADCCFG; // R6
         end
      end else if (page_in >= `PAGE_ADC_B_FIRST && page_in <= `PAGE_ADC_B_LAST) begin
         offs = page_in - `PAGE_ADC_B_FIRST;
         if (coef_reg) begin
            region_out = REGION_COEF; // R3
            slot_out   = SLOT_W'(offs) + SLOT_W'(`SLOT_ADC_B);
         end
      end else if (page_in >= `PAGE_DAC_A_FIRST && page_in <= `PAGE_DAC_A_LAST) begin
         offs = page_in - `PAGE_DAC_A_FIRST;
         if (coef_reg) begin
            region_out = REGION_COEF; // R4
            slot_out   = SLOT_W'(offs) + SLOT_W'(`SLOT_DAC_A);
         end else if (page_in == `PAGE_DAC_A_FIRST && reg_in == `REG_FILT_CFG) begin
            region_out = REGION_DACCFG; // R6
         end
      end else if (page_in >= `PAGE_DAC_B_FIRST && page_in <= `PAGE_DAC_B_LAST) begin
         offs = page_in - `PAGE_DAC_B_FIRST;
         if (coef_reg) begin
            region_out = REGION_COEF; // R5
            slot_out   = SLOT_W'(offs) + SLOT_W'(`SLOT_DAC_B);
         end
      end
   end

endmodule : page_map_decoder

// ==== pkg/codec_clk_defines.svh ====
// Contract
// R1 - Register 0 holds an 8-bit page selector, reset to zero, choosing the page for later accesses.
// R2 - ADC buffer A entries 0-29 sit in registers 8-127 of page 8, entries 30-255 in pages 9-16.
// R3 - ADC buffer B entries 0-255 sit in registers 8-127 of pages 26-34; registers 1-7 are reserved.
// R4 - DAC buffer A entries 0-29 sit in registers 8-127 of page 44, entries 30-255 in pages 45-52.
// R5 - DAC buffer B entries 0-255 sit in registers 8-127 of pages 62-70.
// R6 - ADC adaptive filter config is register 1 of page 8, DAC adaptive filter config register 1 of page 44.
// R7 - Writing one to bit 0 of page-0 register 1 starts a self-clearing soft reset; zero does nothing.
// R8 - The host writes only default values into reserved bits and registers, page-0 regs 2 and 3 included.
// R9 - Bit 6 of clock register 4 picks the PLL range, zero low and one high, reset zero.
// R10 - Bits 3-2 of clock register 4 pick the PLL reference: master, bit clock, GPIO, data-in; reset 00.
// R11 - Bits 1-0 of clock register 4 pick the core clock: master, bit clock, GPIO, PLL output; reset 00.
// R12 - Bit 7 of clock register 5 powers the PLL up when one, down when zero, reset zero.
// R13 - Bits 6-4 of clock register 5 set predivider P: codes 1-7 give 1-7, code 0 gives 8, reset 001.
// R14 - Bits 3-0 of clock register 5 set multiplier R, codes 1-4 only, reset 0001.
// R15 - Register 0 of every page is the page selector.
// R16 - Soft reset returns page select and page-0 clock fields to reset values, page zero selected.
`ifndef CODEC_CLK_DEFINES_SVH
`define CODEC_CLK_DEFINES_SVH

`define REG_PAGE_SEL      7'h00
`define REG_SOFT_RST      7'h01
`define REG_CLK_MUX       7'h04
`define REG_PLL_PR        7'h05
`define REG_FILT_CFG      7'h01
`define REG_COEF_FIRST    7'h08

`define PAGE_ZERO         8'h00
`define PAGE_ADC_A_FIRST  8'h08
`define PAGE_ADC_A_LAST   8'h10
`define PAGE_ADC_B_FIRST  8'h1A
`define PAGE_ADC_B_LAST   8'h22
`define PAGE_DAC_A_FIRST  8'h2C
`define PAGE_DAC_A_LAST   8'h34
`define PAGE_DAC_B_FIRST  8'h3E
`define PAGE_DAC_B_LAST   8'h46

`define SLOT_ADC_A        6'h00
`define SLOT_ADC_B        6'h09
`define SLOT_DAC_A        6'h12
`define SLOT_DAC_B        6'h1B
`define COEF_REGS_PER_PG  13'h0078

`define SRST_BIT          0
`define PLL_RANGE_BIT     6
`define PLL_REF_MSB       3
`define PLL_REF_LSB       2
`define CORE_SRC_MSB      1
`define CORE_SRC_LSB      0
`define PLL_PWR_BIT       7
`define PLL_P_MSB         6
`define PLL_P_LSB         4
`define PLL_R_MSB         3
`define PLL_R_LSB         0

`define PAGE_RST          8'h00
`define PLL_RANGE_RST     1'b0
`define PLL_SRC_RST       2'h0
`define PLL_PWR_RST       1'b0
`define PLL_P_RST         4'h1
`define PLL_R_RST         3'h1
`define FILT_CFG_RST      8'h00
`define PLL_P_EIGHT       4'h8
`define PLL_R_MIN         4'h1
`define PLL_R_MAX         4'h4

`define IDX_LSB           2
`define IDX_MSB           8
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ==== pkg/codec_clk_pkg.sv ====
package codec_clk_pkg;

   typedef enum logic [2:0] {
      REGION_NONE   = 3'b000,
      REGION_SELECT = 3'b001,
      REGION_PAGE0  = 3'b010,
      REGION_ADCCFG = 3'b011,
      REGION_DACCFG = 3'b100,
      REGION_COEF   = 3'b101
   } region_t;

   typedef enum logic [1:0] {
      SRC_MCLK = 2'b00,
      SRC_BCLK = 2'b01,
      SRC_GPIO = 2'b10,
      SRC_ALT  = 2'b11
   } clk_src_t;

endpackage : codec_clk_pkg
